// ===== verilog/at_bus_disk_host_port.sv
// Host-side port of the combined fixed-disk and floppy controller
`timescale 1ns/1ps
`default_nettype none
`include "disk_host_port_params.svh"
module at_bus_disk_host_port
  import disk_host_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic host_rst,
  input wire logic [9:0] host_addr,
  input wire logic aen,
  input wire logic iow_n,
  input wire logic ior_n,
  input wire logic [15:0] sd_in,
  output logic [15:0] sd_out,
  output logic sd_lo_oe_n,
  output logic sd_hi_oe_n,
  output logic iocs16_n,
  input wire logic dack2_n,
  input wire logic tc,
  output logic drq2,
  output logic irq6,
  output logic irq14,
  input wire logic fdc_data_ready,
  input wire logic fdc_cmd_done,
  input wire logic [7:0] fdc_rd_data,
  output logic [7:0] fdc_wr_data,
  output logic fdc_dma_wr,
  output logic fdc_dma_rd,
  output logic fdc_tc,
  input wire logic hd_busy,
  input wire logic hd_attention,
  input wire logic [7:0] hd_task_rd_data,
  output logic [7:0] hd_task_wr_data,
  output logic [2:0] hd_task_sel,
  output logic hd_task_wr,
  input wire logic hd_sector_start,
  input wire logic disk_wr_en,
  input wire logic [7:0] disk_wr_data,
  output logic [7:0] disk_rd_data,
  input wire logic disk_rd_en,
  output logic [10:0] buf_count,
  output logic buf_full,
  output logic [1:0] fd_rate,
  output logic fd_fm_mode,
  output logic vco_300_sel,
  output logic [5:0] precomp_cycles,
  output logic led_on
);
  // ========================================================================
  // Combined reset: async pin and host reset line
  logic rst_n;
  assign rst_n = resetn & ~host_rst;

  // ========================================================================
  // Address decode
  logic hd_data_sel, hd_task_hit, fd_rate_sel, fd_data_sel;
  always_comb begin
    // Address decode ignored while the DMA controller owns the bus; floppy data selected only then, by acknowledge
    hd_data_sel = !aen && host_addr == `HD_DATA_ADDR;
    hd_task_hit = !aen && host_addr >= `HD_TASK_BASE && host_addr <= `HD_TASK_LAST;
    fd_rate_sel = !aen && host_addr == `FD_RATE_ADDR;
    fd_data_sel = aen && !dack2_n;
  end
  // 16-bit select only for the word-wide data port
  assign iocs16_n = ~hd_data_sel;

  // ========================================================================
  // Strobe edge detection (host strobes sampled synchronously)
  logic iow_q, ior_q, iow_rise, ior_fall, ior_act;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      iow_q <= 1'b1;
      ior_q <= 1'b1;
    end else begin
      iow_q <= iow_n;
      ior_q <= ior_n;
    end
  end
  // Write taken as the strobe ends, read as it begins
  assign iow_rise = iow_n && !iow_q;
  assign ior_fall = !ior_n && ior_q;
  assign ior_act = !ior_n;

  // ========================================================================
  // Host write splitter: two byte writes per word
  logic wr_pend_q;
  logic [7:0] wr_hi_q;
  logic [`BUF_AW-1:0] host_ptr_q;
  logic [10:0] count_q;
  logic [`BUF_AW-1:0] disk_ptr_q;
  logic host_wr_lo, host_wr_hi, host_rd_byte;
  logic buf_wr_en;
  logic [`BUF_AW-1:0] buf_wr_addr, buf_rd_addr;
  logic [7:0] buf_wr_data, buf_rd_data;

  // Full at one sector; a word arriving then is dropped whole
  assign buf_full = count_q >= `SECTOR_BYTES;
  assign buf_count = count_q;
  assign host_wr_lo = iow_rise && hd_data_sel && !buf_full;
  assign host_wr_hi = wr_pend_q && !buf_full;

  // Pending upper byte after the lower one is stored
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_hi_q <= 8'h00;
    end else if (host_wr_lo) begin
      wr_pend_q <= 1'b1;
      wr_hi_q <= sd_in[15:8];
    end else if (host_wr_hi) begin
      wr_pend_q <= 1'b0;
    end
  end

  // Buffer write arbitration: host bytes first, disk side otherwise
  always_comb begin
    buf_wr_en = 1'b0;
    buf_wr_addr = disk_ptr_q;
    buf_wr_data = disk_wr_data;
    if (host_wr_lo) begin
      buf_wr_en = 1'b1;
      buf_wr_addr = {host_ptr_q[`BUF_AW-1:1], 1'b0};
      buf_wr_data = sd_in[7:0];
    end else if (host_wr_hi) begin
      buf_wr_en = 1'b1;
      buf_wr_addr = {host_ptr_q[`BUF_AW-1:1], 1'b1};
      buf_wr_data = wr_hi_q;
    end else if (disk_wr_en && !buf_full) begin
      buf_wr_en = 1'b1;
    end
  end

  // ========================================================================
  // Host read assembler: two byte reads form one word
  rd_state_t rd_state_q;
  logic [7:0] rd_lo_q;
  logic [15:0] word_q;
  logic rd_byte_take;
  assign host_rd_byte = (rd_state_q == rd_low) || (rd_state_q == rd_high);
  assign rd_byte_take = host_rd_byte;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_q <= rd_idle;
      rd_lo_q <= 8'h00;
      word_q <= 16'h0000;
    end else begin
      unique case (rd_state_q)
        rd_idle: begin
          if (ior_fall && hd_data_sel && count_q >= 11'h2) begin
            rd_state_q <= rd_low;
          end
        end
        rd_low: begin
          rd_state_q <= rd_high;
        end
        rd_high: begin
          rd_lo_q <= buf_rd_data; // Even byte arrives
          rd_state_q <= rd_done;
        end
        rd_done: begin
          word_q <= {buf_rd_data, rd_lo_q};
          rd_state_q <= rd_idle;
        end
      endcase
    end
  end

  // Host pointer advances per stored or fetched byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      host_ptr_q <= '0;
    end else if (host_wr_lo || host_wr_hi || rd_byte_take) begin
      host_ptr_q <= host_ptr_q + 1'b1;
    end
  end

  // Disk-side pointer, independent of the host pointer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      disk_ptr_q <= '0;
    end else if (hd_sector_start) begin
      disk_ptr_q <= '0;
    end else if ((disk_wr_en && !buf_full && !host_wr_lo && !host_wr_hi) ||
                 (disk_rd_en && count_q != 11'h0 && !rd_byte_take)) begin
      disk_ptr_q <= disk_ptr_q + 1'b1;
    end
  end

  // Disk-side moves, held off while the host uses the same port
  logic disk_wr_ok, disk_rd_ok;
  assign disk_wr_ok = disk_wr_en && !buf_full && !host_wr_lo && !host_wr_hi;
  assign disk_rd_ok = disk_rd_en && count_q != 11'h0 && !rd_byte_take;
  // Occupancy count, never above one sector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 11'h0;
    end else if (hd_sector_start) begin
      count_q <= 11'h0;
    end else begin
      count_q <= count_q + {10'h0, (host_wr_lo || host_wr_hi || disk_wr_ok)}
                 - {10'h0, (rd_byte_take || disk_rd_ok)};
    end
  end

  // Host reads own the read port; a disk read waits up to two cycles
  assign buf_rd_addr = rd_byte_take ? host_ptr_q : disk_ptr_q;

  // Byte store, cleared with the board
  sector_buffer u_buf (
    .clk_sys(clk_sys),
    .resetn(rst_n),
    .wr_en(buf_wr_en),
    .wr_addr(buf_wr_addr),
    .wr_data(buf_wr_data),
    .rd_addr(buf_rd_addr),
    .rd_data(buf_rd_data)
  );
  // Disk side sees the registered read byte
  assign disk_rd_data = buf_rd_data;

  // ========================================================================
  // Task file and floppy byte ports on the low lanes
  assign hd_task_sel = host_addr[2:0];
  assign hd_task_wr = iow_rise && hd_task_hit;
  assign hd_task_wr_data = sd_in[7:0];
  assign fdc_dma_wr = iow_rise && fd_data_sel;
  assign fdc_dma_rd = ior_fall && fd_data_sel;
  assign fdc_wr_data = sd_in[7:0];
  assign fdc_tc = tc && fd_data_sel;

  // Read data mux: high lanes only for the word data port
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sd_out <= 16'h0000;
    end else if (hd_data_sel) begin
      sd_out <= word_q;
    end else if (hd_task_hit) begin
      sd_out <= {8'h00, hd_task_rd_data};
    end else if (fd_data_sel) begin
      sd_out <= {8'h00, fdc_rd_data};
    end else begin
      sd_out <= 16'h0000;
    end
  end

  // Lanes driven only while a selected port is read
  assign sd_lo_oe_n = ~(ior_act && (hd_data_sel || hd_task_hit || fd_data_sel));
  assign sd_hi_oe_n = ~(ior_act && hd_data_sel);

  // ========================================================================
  // Floppy rate, encoding, oscillator and precomp selection
  fd_rate_t rate_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= fd_rate_t'(`RATE_RESET);
    end else if (iow_rise && fd_rate_sel) begin
      rate_q <= fd_rate_t'(sd_in[1:0]);
    end
  end
  assign fd_rate = rate_q;
  assign fd_fm_mode = rate_q == rate_125_fm;
  assign vco_300_sel = rate_q == rate_300_mfm;
  localparam logic [5:0] PRE_STD = 6'(`PRECOMP_STD_CYC);
  localparam logic [5:0] PRE_300 = 6'(`PRECOMP_300_CYC);
  assign precomp_cycles = vco_300_sel ? PRE_300 : PRE_STD;

  // ========================================================================
  // Requests and interrupts
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drq2 <= 1'b0;
    end else begin
      drq2 <= fdc_data_ready && !(tc && fd_data_sel);
    end
  end

  // Floppy completion latched until the next floppy data access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq6 <= 1'b0;
    end else if (fdc_cmd_done) begin
      irq6 <= 1'b1;
    end else if (fdc_dma_rd || fdc_dma_wr) begin
      irq6 <= 1'b0;
    end
  end

  // Fixed-disk attention as a level: rises low to high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq14 <= 1'b0;
    end else begin
      irq14 <= hd_attention;
    end
  end

  // Activity LED, also lit through host reset
  assign led_on = hd_busy || host_rst || !resetn;
endmodule : at_bus_disk_host_port
`default_nettype wire

// ===== pkg/disk_host_port_params.svh
// Constants for the disk host port: addresses, sizes, rates and timing counts
// ==========================================================================
`ifndef DISK_HOST_PORT_PARAMS_SVH
`define DISK_HOST_PORT_PARAMS_SVH
// ==========================================================================
// Host port addresses (10-bit)
`define HD_DATA_ADDR 10'h1F0
`define HD_TASK_BASE 10'h1F1
`define HD_TASK_LAST 10'h1F7
`define FD_DATA_ADDR 10'h3F5
`define FD_RATE_ADDR 10'h3F7
// ==========================================================================
// Buffer geometry
`define BUF_DEPTH 1024
`define BUF_AW 10
`define SECTOR_BYTES 11'h200
// ==========================================================================
// Rate code reset value
`define RATE_RESET 2'h0
// ==========================================================================
// Timing, clk_sys at 200 MHz
`define CLK_PS 5000
`define PRECOMP_STD_PS 125000
`define PRECOMP_300_PS 208300
`define PRECOMP_STD_CYC ((`PRECOMP_STD_PS + `CLK_PS - 1) / `CLK_PS)
`define PRECOMP_300_CYC ((`PRECOMP_300_PS + `CLK_PS - 1) / `CLK_PS)
`endif

// ===== pkg/disk_host_port_pkg.sv
// Types shared by the disk host port modules
package disk_host_port_pkg;
  // Floppy data rate selection
  typedef enum logic [1:0] {
    rate_500_mfm = 2'h0,
    rate_300_mfm = 2'h1,
    rate_250_mfm = 2'h2,
    rate_125_fm = 2'h3
  } fd_rate_t;
  // Word packing state toward the host
  typedef enum logic [1:0] {
    rd_idle,
    rd_low,
    rd_high,
    rd_done
  } rd_state_t;
endpackage : disk_host_port_pkg

// ===== verilog/sector_buffer.sv
// Byte-wide sector store, 1K by 8, in flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "disk_host_port_params.svh"
module sector_buffer
  import disk_host_port_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [`BUF_AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [`BUF_AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem_q [`BUF_DEPTH];
  // ========================================================================
  // Storage, one generate entry per byte
  genvar gi;
  generate
    for (gi = 0; gi < `BUF_DEPTH; gi++) begin : g_byte
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          mem_q[gi] <= 8'h00;
        end else if (wr_en && wr_addr == `BUF_AW'(gi)) begin
          mem_q[gi] <= wr_data;
        end
      end
    end
  endgenerate
  // Registered read port
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule : sector_buffer
`default_nettype wire

// ===== sim/host_port_props.sv
// Checker of port relations for the disk host port
`timescale 1ns/1ps
`default_nettype none
module host_port_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic host_rst,
  input wire logic [9:0] host_addr,
  input wire logic aen,
  input wire logic iow_n,
  input wire logic dack2_n,
  input wire logic fdc_data_ready,
  input wire logic fdc_cmd_done,
  input wire logic hd_busy,
  input wire logic hd_attention,
  input wire logic sd_hi_oe_n,
  input wire logic iocs16_n,
  input wire logic drq2,
  input wire logic irq6,
  input wire logic irq14,
  input wire logic fdc_dma_wr,
  input wire logic [10:0] buf_count,
  input wire logic buf_full,
  input wire logic [1:0] fd_rate,
  input wire logic fd_fm_mode,
  input wire logic vco_300_sel,
  input wire logic [5:0] precomp_cycles,
  input wire logic led_on
);
  // ==========================================================================
  // Clocking and the strobe event of a floppy DMA write
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn || host_rst);
  sequence dma_wr_take;
    aen && !dack2_n && $rose(iow_n);
  endsequence
  // ==========================================================================
  // Assertions
  cs_decode_a: assert property (iocs16_n == !(host_addr == 10'h1F0 && !aen))
    else $error("chip select does not follow the decode");
  hi_lane_a: assert property (!sd_hi_oe_n |-> host_addr == 10'h1F0 && !aen)
    else $error("upper lanes driven outside data port");
  drq_follow_a: assert property (!fdc_data_ready |=> !drq2)
    else $error("DMA request without ready data");
  irq6_set_a: assert property (fdc_cmd_done |=> irq6)
    else $error("floppy completion did not interrupt");
  irq14_edge_a: assert property ($rose(hd_attention) |=> irq14)
    else $error("fixed disk attention not raised");
  dma_pulse_a: assert property (dma_wr_take |-> ##[0:2] fdc_dma_wr)
    else $error("DMA write not passed to floppy port");
  rate_mode_a: assert property (fd_fm_mode == (fd_rate == 2'h3) &&
    vco_300_sel == (fd_rate == 2'h1))
    else $error("encoding or oscillator mismatch");
  precomp_set_a: assert property (precomp_cycles ==
    ((fd_rate == 2'h1) ? 6'h2A : 6'h19))
    else $error("precomp shift wrong for rate");
  buf_cap_a: assert property (buf_count <= 11'h200 &&
    buf_full == (buf_count == 11'h200))
    else $error("buffer occupancy beyond one sector");
  led_lit_a: assert property (disable iff (1'b0)
    led_on == (hd_busy || host_rst || !resetn))
    else $error("activity light wrong");
endmodule : host_port_props
bind at_bus_disk_host_port host_port_props u_props (.*);
`default_nettype wire

// ===== sim/host_dma_model.sv
// Behavioural host processor and DMA controller on the host bus
`timescale 1ns/1ps
`default_nettype none
module host_dma_model (
  input wire logic clk_sys,
  input wire logic [15:0] sd_out,
  output logic [9:0] host_addr,
  output logic aen,
  output logic iow_n,
  output logic ior_n,
  output logic [15:0] sd_in,
  output logic dack2_n,
  output logic tc
);
  // Idle bus at time zero
  initial begin
    host_addr = 10'h000;
    aen = 1'b0;
    iow_n = 1'b1;
    ior_n = 1'b1;
    sd_in = 16'hFFFF;
    dack2_n = 1'b1;
    tc = 1'b0;
  end
  // One write, by the host or the DMA controller
  task automatic bus_wr(input logic [9:0] a, input logic dma, input logic last,
                        input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    host_addr = a;
    aen = dma; // DMA owns the bus
    dack2_n = !dma; // Acknowledge picks the floppy port
    tc = last; // Final byte marked
    sd_in = d;
    iow_n = 1'b0;
    @(posedge clk_sys);
    #1;
    iow_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    sd_in = ~d; // Released bus no longer shows the data
    aen = 1'b0;
    dack2_n = 1'b1;
    tc = 1'b0;
  endtask : bus_wr
  // One host read, strobe held six cycles
  task automatic bus_rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    #1;
    host_addr = a;
    ior_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    d = sd_out;
    ior_n = 1'b1;
  endtask : bus_rd
endmodule : host_dma_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the disk host port
`timescale 1ns/1ps
`default_nettype none
module tb;
  import disk_host_port_pkg::*;
  logic clk_sys, resetn, host_rst, aen, iow_n, ior_n, dack2_n, tc, drq2, irq6, irq14;
  logic sd_lo_oe_n, sd_hi_oe_n, iocs16_n, fdc_data_ready, fdc_cmd_done, fdc_dma_wr;
  logic fdc_dma_rd, fdc_tc, hd_busy, hd_attention, hd_task_wr, hd_sector_start;
  logic disk_wr_en, disk_rd_en, buf_full, fd_fm_mode, vco_300_sel, led_on;
  logic [9:0] host_addr;
  logic [15:0] sd_in, sd_out;
  logic [7:0] fdc_rd_data, fdc_wr_data, hd_task_rd_data, hd_task_wr_data;
  logic [7:0] disk_wr_data, disk_rd_data;
  logic [2:0] hd_task_sel;
  logic [10:0] buf_count;
  logic [1:0] fd_rate;
  logic [5:0] precomp_cycles;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [8:0] dma_seen = 9'h000;
  logic [10:0] task_seen = 11'h000;
  logic [1:0] oe_seen = 2'h3;
  // ==========================================================================
  // Design, host model and clock
  at_bus_disk_host_port DUT (.*);
  host_dma_model host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      final_report();
    end
  end
  // Capture of one-cycle strobes and lane enables for later comparison
  always @(posedge clk_sys) begin
    if (fdc_dma_wr) dma_seen <= {fdc_tc, fdc_wr_data};
    if (hd_task_wr) task_seen <= {hd_task_sel, hd_task_wr_data};
    if (!ior_n) oe_seen <= {sd_hi_oe_n, sd_lo_oe_n};
  end
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic hrst;
    @(posedge clk_sys);
    #1;
    host_rst = 1'b1;
    @(posedge clk_sys);
    #1;
    chk(led_on, 1'b1);
    host_rst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : hrst
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Scenarios
  task automatic t_read;
    logic [15:0] d;
    @(posedge clk_sys);
    #1;
    disk_wr_en = 1'b1;
    for (int i = 0; i < 4; i++) begin
      disk_wr_data = 8'hA1 + 8'(i * 17);
      @(posedge clk_sys);
      #1;
    end
    disk_wr_en = 1'b0;
    host.bus_rd(10'h1F0, d);
    chk(d, 16'hB2A1); // First pair, even byte low
    chk(oe_seen, 16'h0000); // Both lanes for the word port
    host.bus_rd(10'h1F0, d);
    chk(d, 16'hD4C3);
    $display("t_read done");
  endtask : t_read
  task automatic t_dma;
    fdc_data_ready = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(drq2, 1'b1);
    host.bus_wr(10'h1F0, 1'b1, 1'b1, 16'h7E3C);
    chk(buf_count, 16'h0000); // Decode ignored under DMA
    chk(dma_seen, 16'h013C); // Low lanes and terminal count to floppy
    fdc_data_ready = 1'b0;
    fdc_cmd_done = 1'b1;
    @(posedge clk_sys);
    #1;
    fdc_cmd_done = 1'b0;
    chk(irq6, 1'b1);
    chk(irq14, 1'b0);
    $display("t_dma done");
  endtask : t_dma
  task automatic t_hd;
    hd_attention = 1'b1;
    hd_busy = 1'b1;
    @(posedge clk_sys);
    #1;
    chk(irq14, 1'b1);
    chk(drq2, 1'b0);
    chk(led_on, 1'b1);
    hd_attention = 1'b0;
    hd_busy = 1'b0;
    $display("t_hd done");
  endtask : t_hd
  task automatic t_task;
    logic [15:0] d;
    host.bus_wr(10'h1F3, 1'b0, 1'b0, 16'hAA55);
    chk(task_seen, 16'h0355); // Register select and low lane byte
    host.bus_rd(10'h1F3, d);
    chk(d, 16'h00C3); // Status on low lanes only
    chk(oe_seen, 16'h0002); // Upper lanes stay off
    $display("t_task done");
  endtask : t_task
  task automatic t_write;
    hrst();
    for (int i = 0; i < 257; i++) begin
      host.bus_wr(10'h1F0, 1'b0, 1'b0, {8'hA5, 8'(i)});
      if (i == 0) chk(buf_count, 16'h0002);
    end
    chk(buf_count, 16'h0200); // Extra word refused
    chk(buf_full, 1'b1);
    disk_rd_en = 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      #1;
      chk(disk_rd_data, (k == 1) ? 16'h00A5 : 16'(k / 2));
    end
    disk_rd_en = 1'b0;
    hd_sector_start = 1'b1;
    @(posedge clk_sys);
    #1;
    hd_sector_start = 1'b0;
    chk(buf_count, 16'h0000); // Sector start empties the buffer
    $display("t_write done");
  endtask : t_write
  task automatic t_rate;
    for (int r = 0; r < 4; r++) begin
      host.bus_wr(10'h3F7, 1'b0, 1'b0, 16'(r));
      chk(fd_rate, 16'(r));
      chk(fd_fm_mode, 16'(r == 3));
      chk(vco_300_sel, 16'(r == 1));
      chk(precomp_cycles, (r == 1) ? 16'h002A : 16'h0019);
    end
    hrst();
    chk(fd_rate, 16'h0000);
    chk(buf_count, 16'h0000);
    $display("t_rate done");
  endtask : t_rate
  // Main sequence
  initial begin
    {resetn, host_rst, fdc_data_ready, fdc_cmd_done, hd_busy, hd_attention} = 6'h00;
    {hd_sector_start, disk_wr_en, disk_rd_en} = 3'h0;
    {fdc_rd_data, hd_task_rd_data, disk_wr_data} = 24'h5AC300;
    repeat (10) @(posedge clk_sys);
    #1;
    chk(led_on, 1'b1);
    resetn = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(sd_out, 16'h0000);
    chk({irq6, irq14, drq2, fd_rate}, 16'h0000);
    t_read();
    t_dma();
    t_hd();
    t_task();
    t_write();
    t_rate();
    final_report();
  end
endmodule : tb
`default_nettype wire
